// [common/pfs_pkg.sv]
package pfs_pkg;
	localparam int          PFS_AW      = 5;
	localparam int          PFS_DW      = 32;
	localparam int          PFS_PINS    = 8;
	// Register byte offsets
	localparam logic [4:0]  OFF_DATA    = 5'h00;
	localparam logic [4:0]  OFF_DIR     = 5'h04;
	localparam logic [4:0]  OFF_PULLUP  = 5'h08;
	localparam logic [4:0]  OFF_TB      = 5'h0C;
	localparam logic [4:0]  OFF_TA      = 5'h10;
	localparam logic [4:0]  OFF_PER     = 5'h14;
	localparam logic [4:0]  OFF_UIR     = 5'h18;
	localparam logic [4:0]  OFF_STAT    = 5'h1C;
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [7:0]  PORT_MASK   = 8'hFE;
	localparam logic [7:0]  PULLUP_MASK = 8'h03;
	localparam logic [7:0]  TB_MASK     = 8'h0F;
	localparam logic [7:0]  TA_MASK     = 8'h1F;
	localparam logic [7:0]  UIR_MASK    = 8'h7F;
	localparam logic [7:0]  PER_MASK    = 8'hFF;
	// Pull-up control fields
	localparam int          PU_LOW      = 0;
	localparam int          PU_HIGH     = 1;
	// Timer B io/mode fields
	localparam int          TB_SEL      = 0;
	localparam int          TB_OCTL     = 1;
	localparam int          TB_MODE     = 2;
	localparam logic [1:0]  TB_MODE_OFF = 2'h0;
	// Timer A io/mode fields
	localparam int          TA_SEL      = 0;
	localparam int          TA_POL      = 1;
	localparam int          TA_MODE     = 2;
	localparam logic [2:0]  TA_MODE_TMR = 3'h0;
	localparam logic [2:0]  TA_MODE_PLS = 3'h1;
	// Peripheral enable fields
	localparam int          PER_TF1     = 0;
	localparam int          PER_TF2     = 1;
	localparam int          PER_KI1     = 2;
	localparam int          PER_KI2     = 3;
	localparam int          PER_KI3     = 4;
	localparam int          PER_CIN1    = 5;
	localparam int          PER_CIN2    = 6;
	localparam int          PER_CO1     = 7;
	// Comparator 2, UART and interrupt fields
	localparam int          UIR_CO2     = 0;
	localparam int          UIR_TXEN    = 1;
	localparam int          UIR_OD      = 2;
	localparam int          UIR_CKDIR   = 3;
	localparam int          UIR_SYNC    = 4;
	localparam int          UIR_IRQEN   = 5;
	localparam int          UIR_IRQSEL  = 6;
	// Pin indices
	localparam int          PIN_1       = 1;
	localparam int          PIN_2       = 2;
	localparam int          PIN_3       = 3;
	localparam int          PIN_4       = 4;
	localparam int          PIN_5       = 5;
	localparam int          PIN_6       = 6;
	localparam int          PIN_7       = 7;
	localparam int          STAT_CONFL  = 0;
	typedef logic [7:0] pfs_byte_t;
endpackage

// [rtl/pfs_port1_mux.sv]
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pfs_port1_mux (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [pfs_pkg::PFS_AW-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [pfs_pkg::PFS_DW-1:0] avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic [pfs_pkg::PFS_DW-1:0]  avs_readdata,
	output logic                        avs_waitrequest,
	input  wire logic [7:0]             pin_in,
	output logic [7:0]                  pin_out,
	output logic [7:0]                  pin_oe,
	output logic [7:0]                  pin_pullup,
	input  wire logic                   timer_f_output01,
	input  wire logic                   timer_f_output02,
	input  wire logic                   timer_b_output,
	input  wire logic                   timer_a_output,
	input  wire logic                   comparator1_out,
	input  wire logic                   comparator2_out,
	input  wire logic                   uart0_transmit,
	input  wire logic                   uart0_clock_out,
	output logic                        key_input1,
	output logic                        key_input2,
	output logic                        key_input3,
	output logic                        comparator_in1,
	output logic                        comparator_in2,
	output logic                        uart0_receive,
	output logic                        uart0_clock_in,
	output logic                        timer_a_io_pin,
	output logic                        irq1_input
);
	import pfs_pkg::*;

	function automatic pfs_byte_t wr_byte(input pfs_byte_t wd, input pfs_byte_t mask);
		wr_byte = wd & mask;
	endfunction

	pfs_byte_t latch_q, port1_direction_reg_q, pullup_control_reg0_q;
	pfs_byte_t timer_b_io_control_reg_q, timer_a_io_control_reg_q, per_q, uir_q;
	logic      ack_q;
	logic      wr_ok;
	pfs_byte_t out_d, oe_d, pu_d, claim_d, rd_byte;
	logic      conflict_d;
	logic      tb_use, ta_out_use, ta_in_use, key3_use;
	logic [2:0] ta_pin;
	logic [1:0] tb_mode;
	logic [2:0] ta_mode;

	// One wait cycle per access keeps read data registered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_ok = avs_write & ack_q & avs_byteenable[0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_q               <= RST_BYTE;
			port1_direction_reg_q <= RST_BYTE;
			pullup_control_reg0_q <= RST_BYTE;
		end else if (wr_ok) begin
			if (avs_address == OFF_DATA)
				latch_q <= wr_byte(avs_writedata[7:0], PORT_MASK);
			if (avs_address == OFF_DIR)
				port1_direction_reg_q <= wr_byte(avs_writedata[7:0], PORT_MASK);
			if (avs_address == OFF_PULLUP)
				pullup_control_reg0_q <= wr_byte(avs_writedata[7:0], PULLUP_MASK);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_b_io_control_reg_q <= RST_BYTE;
			timer_a_io_control_reg_q <= RST_BYTE;
			per_q                    <= RST_BYTE;
			uir_q                    <= RST_BYTE;
		end else if (wr_ok) begin
			if (avs_address == OFF_TB)
				timer_b_io_control_reg_q <= wr_byte(avs_writedata[7:0], TB_MASK);
			if (avs_address == OFF_TA)
				timer_a_io_control_reg_q <= wr_byte(avs_writedata[7:0], TA_MASK);
			if (avs_address == OFF_PER)
				per_q <= wr_byte(avs_writedata[7:0], PER_MASK);
			if (avs_address == OFF_UIR)
				uir_q <= wr_byte(avs_writedata[7:0], UIR_MASK);
		end
	end

	// input-mode bits read the pin, output-mode bits the latch
	always_comb begin
		unique case (avs_address)
			OFF_DATA:   rd_byte = ((latch_q & port1_direction_reg_q)
				| (pin_in & ~port1_direction_reg_q)) & PORT_MASK;
			OFF_DIR:    rd_byte = port1_direction_reg_q;
			OFF_PULLUP: rd_byte = pullup_control_reg0_q;
			OFF_TB:     rd_byte = timer_b_io_control_reg_q;
			OFF_TA:     rd_byte = timer_a_io_control_reg_q;
			OFF_PER:    rd_byte = per_q;
			OFF_UIR:    rd_byte = uir_q;
			OFF_STAT:   rd_byte = claim_d | {7'h00, conflict_d};
			default:    rd_byte = RST_BYTE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack_q) begin
			avs_readdata <= {24'h00_0000, rd_byte};
		end
	end

	assign tb_mode = timer_b_io_control_reg_q[TB_MODE +: 2];
	assign ta_mode = timer_a_io_control_reg_q[TA_MODE +: 3];
	assign ta_pin  = timer_a_io_control_reg_q[TA_SEL] ? 3'(PIN_5) : 3'(PIN_7);

	// timer B claims pin 3 only with output control 0 and a generation mode
	assign tb_use = timer_b_io_control_reg_q[TB_SEL] & ~timer_b_io_control_reg_q[TB_OCTL]
		& (tb_mode != TB_MODE_OFF);
	// pulse mode with polarity 0 drives the selected pin
	assign ta_out_use = (ta_mode == TA_MODE_PLS) & ~timer_a_io_control_reg_q[TA_POL];
	// timer A input on the selected pin
	assign ta_in_use = ~port1_direction_reg_q[ta_pin] & ~timer_a_io_control_reg_q[TA_POL]
		& (ta_mode != TA_MODE_TMR) & (ta_mode != TA_MODE_PLS);
	// key input 3 only when nothing drives pin 3
	assign key3_use = ~port1_direction_reg_q[PIN_3] & per_q[PER_KI3] & ~per_q[PER_CO1] & ~tb_use;

	always_comb begin
		out_d      = latch_q & PORT_MASK;
		oe_d       = port1_direction_reg_q & PORT_MASK;
		claim_d    = RST_BYTE;
		conflict_d = 1'b0;
		// timer F output 01 on pin 1
		if (per_q[PER_TF1] & ~per_q[PER_KI1] & ~per_q[PER_CIN1]) begin
			out_d[PIN_1]   = timer_f_output01;
			oe_d[PIN_1]    = 1'b1;
			claim_d[PIN_1] = 1'b1;
		end
		if (per_q[PER_TF2] & ~per_q[PER_KI2] & ~per_q[PER_CIN2]) begin
			out_d[PIN_2]   = timer_f_output02;
			oe_d[PIN_2]    = 1'b1;
			claim_d[PIN_2] = 1'b1;
		end
		// pin 3 driven whatever its direction bit
		if (per_q[PER_CO1] & ~per_q[PER_KI3] & ~tb_use) begin
			out_d[PIN_3]   = comparator1_out;
			oe_d[PIN_3]    = 1'b1;
			claim_d[PIN_3] = 1'b1;
		end else if (tb_use & ~per_q[PER_KI3] & ~per_q[PER_CO1]) begin
			out_d[PIN_3]   = timer_b_output;
			oe_d[PIN_3]    = 1'b1;
			claim_d[PIN_3] = 1'b1;
		end
		// open drain only ever drives low
		if (uir_q[UIR_TXEN]) begin
			out_d[PIN_4]   = uir_q[UIR_OD] ? 1'b0 : uart0_transmit;
			oe_d[PIN_4]    = uir_q[UIR_OD] ? ~uart0_transmit : 1'b1;
			claim_d[PIN_4] = 1'b1;
		end
		// timer A output, direction bit ignored
		if (ta_out_use) begin
			out_d[ta_pin]   = timer_a_output;
			oe_d[ta_pin]    = 1'b1;
			claim_d[ta_pin] = 1'b1;
		end
		if (uir_q[UIR_CO2]) begin
			out_d[PIN_6]   = comparator2_out;
			oe_d[PIN_6]    = 1'b1;
			claim_d[PIN_6] = 1'b1;
		end else if (~uir_q[UIR_CKDIR] & uir_q[UIR_SYNC]) begin
			out_d[PIN_6]   = uart0_clock_out;
			oe_d[PIN_6]    = 1'b1;
			claim_d[PIN_6] = 1'b1;
		end
		// overlapping claims on pins 1 to 3 are unsupported and flagged
		conflict_d = (per_q[PER_TF1] & (per_q[PER_KI1] | per_q[PER_CIN1]))
			| (per_q[PER_TF2] & (per_q[PER_KI2] | per_q[PER_CIN2]))
			| ((per_q[PER_CO1] | tb_use) & per_q[PER_KI3])
			| (per_q[PER_CO1] & tb_use);
	end

	// low group pull-up on undriven pins 1 to 3
	// high group pull-up on undriven pins 4 to 7
	always_comb begin
		pu_d = RST_BYTE;
		for (int i = PIN_1; i <= PIN_7; i++) begin
			if (i <= PIN_3)
				pu_d[i] = pullup_control_reg0_q[PU_LOW] & ~oe_d[i];
			else
				pu_d[i] = pullup_control_reg0_q[PU_HIGH] & ~oe_d[i];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_out    <= RST_BYTE;
			pin_oe     <= RST_BYTE;
			pin_pullup <= RST_BYTE;
		end else begin
			pin_out    <= out_d;
			pin_oe     <= oe_d;
			pin_pullup <= pu_d;
		end
	end

	// Idle levels: key and receive lines rest high so no false edge is seen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_input1     <= 1'b1;
			key_input2     <= 1'b1;
			key_input3     <= 1'b1;
			comparator_in1 <= 1'b0;
			comparator_in2 <= 1'b0;
			uart0_receive  <= 1'b1;
			uart0_clock_in <= 1'b0;
			timer_a_io_pin <= 1'b0;
			irq1_input     <= 1'b0;
		end else begin
			key_input1 <= (~oe_d[PIN_1] & per_q[PER_KI1] & ~per_q[PER_CIN1]) ? pin_in[PIN_1] : 1'b1;
			key_input2 <= (~oe_d[PIN_2] & per_q[PER_KI2] & ~per_q[PER_CIN2]) ? pin_in[PIN_2] : 1'b1;
			// key input 3 follows the pin
			key_input3 <= key3_use ? pin_in[PIN_3] : 1'b1;
			comparator_in1 <= (~oe_d[PIN_1] & per_q[PER_CIN1]) ? pin_in[PIN_1] : 1'b0;
			comparator_in2 <= (~oe_d[PIN_2] & per_q[PER_CIN2]) ? pin_in[PIN_2] : 1'b0;
			uart0_receive  <= ~oe_d[PIN_5] ? pin_in[PIN_5] : 1'b1;
			uart0_clock_in <= (~oe_d[PIN_6] & uir_q[UIR_CKDIR]) ? pin_in[PIN_6] : 1'b0;
			// timer A input and interrupt 1 share the selected pin
			timer_a_io_pin <= ta_in_use ? pin_in[ta_pin] : 1'b0;
			irq1_input     <= (~oe_d[ta_pin] & uir_q[UIR_IRQEN] & ~uir_q[UIR_IRQSEL])
				? pin_in[ta_pin] : 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_bus_wait_one: assert property ((avs_read | avs_write) & avs_waitrequest
		|=> !avs_waitrequest) else $error("waitrequest held more than one cycle");
	a_latch_drive: assert property (wr_ok & (avs_address == OFF_DATA)
		##1 (per_q == RST_BYTE) & (uir_q == RST_BYTE) & (ta_mode == TA_MODE_TMR) & ~tb_use
		|=> (pin_out & pin_oe) == (latch_q & port1_direction_reg_q))
		else $error("latch value not driven on output pins");
	a_pullup_low: assert property (pullup_control_reg0_q[PU_LOW] & ~oe_d[PIN_2]
		|=> pin_pullup[PIN_2]) else $error("pin 2 pull-up missing");
	a_pullup_high: assert property (pin_oe[PIN_6] |-> !pin_pullup[PIN_6])
		else $error("pull-up on driven pin 6");
	a_tx_open_drain: assert property (uir_q[UIR_TXEN] & uir_q[UIR_OD]
		|=> !pin_out[PIN_4] && (pin_oe[PIN_4] == !$past(uart0_transmit)))
		else $error("open-drain transmit drives high");
	a_tb_pin_drive: assert property (tb_use & ~per_q[PER_KI3] & ~per_q[PER_CO1]
		|=> pin_oe[PIN_3] && (pin_out[PIN_3] == $past(timer_b_output)))
		else $error("timer B output not on pin 3");
	a_tb_dir_free: assert property (tb_use & ~per_q[PER_KI3] & ~per_q[PER_CO1]
		& ~port1_direction_reg_q[PIN_3] |=> pin_oe[PIN_3])
		else $error("timer B output blocked by direction");
	a_key3_follow: assert property (key3_use |=> key_input3 == $past(pin_in[PIN_3]))
		else $error("key input 3 does not follow pin");
	a_tf1_drive: assert property (per_q[PER_TF1] & ~per_q[PER_KI1] & ~per_q[PER_CIN1]
		|=> pin_oe[PIN_1] && (pin_out[PIN_1] == $past(timer_f_output01)))
		else $error("timer F output 01 not on pin 1");
	a_ta_input: assert property (ta_in_use & timer_a_io_control_reg_q[TA_SEL]
		|=> timer_a_io_pin == $past(pin_in[PIN_5])) else $error("timer A input not from pin 5");
	a_ta_output: assert property (ta_out_use & ~timer_a_io_control_reg_q[TA_SEL]
		|=> pin_oe[PIN_7] && (pin_out[PIN_7] == $past(timer_a_output)))
		else $error("timer A output not on pin 7");
	a_port_default: assert property (~per_q[PER_TF2] & ~uir_q[UIR_CO2]
		|=> (pin_oe[PIN_2] == $past(port1_direction_reg_q[PIN_2])))
		else $error("unclaimed pin 2 ignores direction");
	a_tx_pin_free: assert property (~uir_q[UIR_TXEN]
		|=> (pin_oe[PIN_4] == $past(port1_direction_reg_q[PIN_4])))
		else $error("unclaimed pin 4 ignores direction");
	a_pullup_pin6: assert property (pullup_control_reg0_q[PU_HIGH] & ~oe_d[PIN_6]
		|=> pin_pullup[PIN_6]) else $error("pin 6 pull-up missing");

	c_tb_out: cover property (tb_use ##1 pin_oe[PIN_3]);
	c_ta_in: cover property (ta_in_use ##1 timer_a_io_pin);
	c_tx_od: cover property (uir_q[UIR_TXEN] & uir_q[UIR_OD] & ~uart0_transmit);
	c_read: cover property (avs_read & !avs_waitrequest & (avs_address == OFF_DATA));
endmodule
`default_nettype wire

// [tb/pfs_periph_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pfs_periph_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] lvl_set,
	output logic [7:0]      pin_in,
	output logic [7:0]      per_q
);
	logic [7:0] last_q;
	// Peripheral outputs come from flops, as the on-chip timers present them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			per_q <= 8'h00;
			last_q <= 8'h00;
		end else begin
			per_q <= lvl_set;
			last_q <= pin_in;
		end
	end
	// A floating pin wanders so a stale level can never pass for a driven one
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & pin_pullup) | (~pin_oe & ~ext_en & ~pin_pullup & ~last_q);
endmodule
`default_nettype wire

// [tb/port1_pin_function_select_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module port1_pin_function_select_tb_top;
	import pfs_pkg::*;
	logic        clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val, lvl_set, per;
	logic        key_input1, key_input2, key_input3, comparator_in1, comparator_in2;
	logic        uart0_receive, uart0_clock_in, timer_a_io_pin, irq1_input;
	int          n_errors = 0;
	int          cmp_count = 0;

	pfs_port1_mux uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.timer_f_output01(per[0]), .timer_f_output02(per[1]), .timer_b_output(per[2]),
		.timer_a_output(per[3]), .comparator1_out(per[4]), .comparator2_out(per[5]),
		.uart0_transmit(per[6]), .uart0_clock_out(per[7]), .key_input1(key_input1),
		.key_input2(key_input2), .key_input3(key_input3), .comparator_in1(comparator_in1),
		.comparator_in2(comparator_in2), .uart0_receive(uart0_receive),
		.uart0_clock_in(uart0_clock_in), .timer_a_io_pin(timer_a_io_pin),
		.irq1_input(irq1_input));
	pfs_periph_model model (.clk(clk), .rst(rst), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .lvl_set(lvl_set),
		.pin_in(pin_in), .per_q(per));

	initial clk = 1'b0;
	always #5 clk = ~clk;

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until the rising edge at which waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) begin
			n_errors++;
			print_verdict();
		end
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	// Model flop plus design flop, then look mid-cycle
	task automatic setx(input logic [7:0] en, input logic [7:0] val, input logic [7:0] lvl);
		@(posedge clk);
		ext_en <= en;
		ext_val <= val;
		lvl_set <= lvl;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic t_reset();
		for (int i = 0; i < 8; i++) rd(5'(i * 4), 8'h00);
		rd(5'h02, 8'h00);
		@(negedge clk);
		// Pin 5 rests at the external low level and receive follows it
		chk({4'h0, key_input3, key_input2, key_input1, uart0_receive}, 8'h0E);
		chk(pin_oe | pin_pullup | pin_out, 8'h00);
	endtask
	task automatic t_port();
		wr(OFF_DIR, 8'hA0);
		wr(OFF_DATA, 8'hFE);
		setx(8'hFF, 8'h54, 8'h00);
		chk(pin_oe, 8'hA0);
		chk(pin_out & pin_oe, 8'hA0);
		rd(OFF_DATA, 8'hF4);
		wr(OFF_DATA, 8'h20);
		setx(8'hFF, 8'h54, 8'h00);
		chk(pin_out & pin_oe, 8'h20);
		rd(OFF_DATA, 8'h74);
		wr(OFF_DIR, 8'h00);
		setx(8'hFF, 8'h54, 8'h00);
		chk(pin_oe, 8'h00);
	endtask
	task automatic t_pullup();
		logic [7:0] e;
		for (int p = 1; p < 4; p++) begin
			wr(OFF_PULLUP, 8'(p));
			setx(8'h00, 8'h00, 8'h00);
			e = ((p & 1) != 0 ? 8'h0E : 8'h00) | ((p & 2) != 0 ? 8'hF0 : 8'h00);
			chk(pin_pullup, e);
			chk(pin_in & e, e);
		end
		wr(OFF_DIR, 8'hFE);
		setx(8'h00, 8'h00, 8'h00);
		chk(pin_pullup, 8'h00);
		wr(OFF_DIR, 8'h00);
		wr(OFF_PULLUP, 8'h00);
	endtask
	task automatic t_timer_b();
		// Output control set only in waveform mode, as software must
		logic [7:0] cfg [6] = '{8'h05, 8'h09, 8'h0D, 8'h01, 8'h07, 8'h04};
		for (int i = 0; i < 6; i++) begin
			wr(OFF_TB, cfg[i]);
			for (int v = 0; v < 2; v++) begin
				setx(8'hFF, 8'h00, 8'(v << 2));
				chk({7'h00, pin_oe[3]}, 8'(i < 3));
				if (i < 3) chk({7'h00, pin_out[3]}, 8'(v));
			end
			rd(OFF_STAT, i < 3 ? 8'h08 : 8'h00);
		end
		wr(OFF_TB, 8'h00);
		wr(OFF_PER, 8'h10);
		for (int v = 0; v < 2; v++) begin
			setx(8'hFF, 8'(v << 3), 8'h00);
			chk({7'h00, key_input3}, 8'(v));
		end
		wr(OFF_DIR, 8'h08);
		setx(8'hFF, 8'h00, 8'h00);
		chk({7'h00, key_input3}, 8'h01);
		wr(OFF_DIR, 8'h00);
		wr(OFF_PER, 8'h00);
	endtask
	task automatic t_timer_f_uart();
		wr(OFF_PER, 8'h01);
		for (int v = 0; v < 2; v++) begin
			setx(8'hFF, 8'h00, 8'(v));
			chk({6'h00, pin_oe[1], pin_out[1]}, 8'(2 + v));
		end
		wr(OFF_PER, 8'h00);
		for (int od = 0; od < 2; od++) begin
			wr(OFF_UIR, od != 0 ? 8'h06 : 8'h02);
			for (int v = 0; v < 2; v++) begin
				setx(8'hFF, 8'h00, 8'(v << 6));
				chk({6'h00, pin_oe[4], pin_out[4]}, od != 0 ? 8'(2 - 2 * v) : 8'(2 + v));
			end
		end
		wr(OFF_UIR, 8'h00);
	endtask
	task automatic t_timer_a();
		int pn;
		for (int s = 0; s < 2; s++) begin
			pn = s != 0 ? 5 : 7;
			wr(OFF_TA, 8'(4 + s));
			for (int v = 0; v < 2; v++) begin
				setx(8'hFF, 8'h00, 8'(v << 3));
				chk({6'h00, pin_oe[pn], pin_out[pn]}, 8'(2 + v));
			end
			wr(OFF_TA, 8'(8 + s));
			wr(OFF_UIR, 8'h20);
			for (int v = 0; v < 2; v++) begin
				setx(8'hFF, 8'(v << pn), 8'h00);
				chk({6'h00, timer_a_io_pin, irq1_input}, 8'(3 * v));
			end
			// Polarity set only in pulse output mode
			wr(OFF_TA, 8'(6 + s));
			setx(8'hFF, 8'h00, 8'h08);
			chk({7'h00, pin_oe[pn]}, 8'h00);
			wr(OFF_UIR, 8'h00);
			wr(OFF_TA, 8'h00);
		end
	endtask
	task automatic t_misc();
		for (int v = 0; v < 2; v++) begin
			wr(OFF_PER, 8'h60);
			setx(8'hFF, 8'(6 * v), 8'h00);
			chk({6'h00, comparator_in2, comparator_in1}, 8'(3 * v));
			wr(OFF_PER, 8'h0C);
			setx(8'hFF, 8'(6 * v), 8'h00);
			chk({6'h00, key_input2, key_input1}, 8'(3 * v));
			wr(OFF_PER, 8'h80);
			setx(8'hFF, 8'h00, 8'(v << 4));
			chk({6'h00, pin_oe[3], pin_out[3]}, 8'(2 + v));
			wr(OFF_UIR, 8'h01);
			setx(8'hFF, 8'h00, 8'(v << 5));
			chk({6'h00, pin_oe[6], pin_out[6]}, 8'(2 + v));
			wr(OFF_UIR, 8'h10);
			setx(8'hFF, 8'h00, 8'(v << 7));
			chk({6'h00, pin_oe[6], pin_out[6]}, 8'(2 + v));
			wr(OFF_UIR, 8'h08);
			setx(8'hFF, 8'(96 * v), 8'h00);
			chk({6'h00, uart0_clock_in, uart0_receive}, 8'(3 * v));
		end
		wr(OFF_UIR, 8'h00);
		// Overlapping claims leave pin 1 to the port and raise the flag
		wr(OFF_PER, 8'h05);
		setx(8'hFF, 8'h00, 8'h01);
		chk({7'h00, pin_oe[1]}, 8'h00);
		rd(OFF_STAT, 8'h01);
		avs_byteenable <= 4'hE;
		wr(OFF_DIR, 8'hFE);
		avs_byteenable <= 4'hF;
		rd(OFF_DIR, 8'h00);
		wr(OFF_DIR, 8'hFE);
		wr(OFF_PULLUP, 8'h03);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(negedge clk);
		chk(pin_oe | pin_pullup | pin_out, 8'h00);
		rd(OFF_DIR, 8'h00);
		rd(OFF_PER, 8'h00);
	endtask

	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		ext_en = 8'hFF;
		ext_val = 8'h00;
		lvl_set = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		$display("reset test done");
		t_port();
		$display("port test done");
		t_pullup();
		$display("pull-up test done");
		t_timer_b();
		$display("timer b test done");
		t_timer_f_uart();
		$display("timer f and uart test done");
		t_timer_a();
		$display("timer a test done");
		t_misc();
		$display("misc test done");
		print_verdict();
	end
endmodule
`default_nettype wire
